// *** core/nvc_pkg.sv ***
// package: register map, field positions and reset values for the nv access block
package nvc_pkg;
	// wishbone byte offsets, one aligned word per register
	localparam logic [3:0] NVC_OFS_CTRL   = 4'h0; // nv_control_reg
	localparam logic [3:0] NVC_OFS_LOC    = 4'h4; // nv_location_reg
	localparam logic [3:0] NVC_OFS_VALUE  = 4'h8; // nv_value_reg
	localparam logic [3:0] NVC_OFS_STAT   = 4'hc; // event status, read clears
	localparam logic [4:0] NVC_OFS_MASK_B = 5'h10; // interrupt mask
	localparam logic [4:0] NVC_OFS_FAULT  = 5'h14; // fault inject (aborting resets)
	// control register fields
	localparam int NVC_BIT_FETCH = 0; // fetch start
	localparam int NVC_BIT_STORE = 1; // store start
	localparam int NVC_BIT_EN    = 2; // store_enable_bit
	localparam int NVC_BIT_ABORT = 3; // store_abort_flag
	// status / mask fields
	localparam int NVC_EV_DONE  = 0; // store_done_flag
	localparam int NVC_EV_ABORT = 1; // write aborted
	localparam int NVC_EV_FETCH = 2; // fetch finished
	localparam int NVC_EV_W     = 3;
	// reset values
	localparam logic [7:0] NVC_RST_BYTE = 8'h00;
	localparam logic [NVC_EV_W-1:0] NVC_RST_EV = 3'h0;
	// store cycle length in clock cycles
	localparam int NVC_STORE_CYC = 40;
	// store engine states
	typedef enum logic [1:0] {
		NVC_IDLE = 2'b01,
		NVC_BUSY = 2'b10
	} nvc_state_e;
endpackage

// *** core/nvc_top.sv ***
// nvc_top: control and status logic for byte access to an on-chip data store
// How it works
// - abort flag 1 on cut write, 0 normal
// - writes only allowed while enable bit set
// - store start set-only, write 0 ignored
// - fetch start one cycle, hardware clears
// - fetched byte valid next cycle
// - value held until fetch or sw write
// - abort on clear, watchdog or brownout reset
// - store end clears start, sets done flag
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
module nvc_top
	import nvc_pkg::*;
#(
	parameter int ADDR_W    = 7,                // location width
	parameter int STORE_CYC = NVC_STORE_CYC     // store cycle length
) (
	input  wire logic              clk_i,       // 10 mhz clock
	input  wire logic              rst_i,       // sync reset, high
	input  wire logic              ce_i,        // clock enable
	input  wire logic              cyc_i,       // wishbone cycle
	input  wire logic              stb_i,       // wishbone strobe
	input  wire logic              we_i,        // wishbone write
	input  wire logic [4:0]        adr_i,       // byte address
	input  wire logic [3:0]        sel_i,       // byte enables
	input  wire logic [31:0]       dat_i,       // write data
	output logic      [31:0]       dat_o,       // read data
	output logic                   ack_o,       // wishbone ack
	output logic                   irq_o,       // level interrupt
	output logic [ADDR_W-1:0]      arr_addr_o,  // array address
	output logic                   arr_we_o,    // array write pulse
	output logic [7:0]             arr_wdata_o, // array write data
	input  wire logic [7:0]        arr_rdata_i  // array read data, async
);
	// elaboration check
	// the cycle counter is 16 bits wide and the location at most one byte
	if (ADDR_W < 1 || ADDR_W > 8 || STORE_CYC < 2 || STORE_CYC > 65535) begin : g_chk
		$error("nvc_top: unsupported parameter value");
	end

	// register state
	logic [ADDR_W-1:0]   loc_ff;    // nv_location_reg
	logic [7:0]          value_ff;  // nv_value_reg
	logic                en_ff;     // store_enable_bit
	logic                abort_ff;  // store_abort_flag
	logic                fetch_ff;  // fetch start bit, one cycle high
	logic [NVC_EV_W-1:0] stat_ff;   // sticky events
	logic [NVC_EV_W-1:0] mask_ff;   // interrupt mask
	logic [15:0]         cnt_ff;    // store cycle counter
	nvc_state_e          st_ff;     // store engine state
	logic [31:0]         dat_ff;    // read data
	logic                ack_ff;    // ack
	logic                irq_ff;    // interrupt

	// bus decode
	// a held request is taken once: ack_ff blanks the cycle in which it stands
	wire acc      = cyc_i & stb_i & ~ack_ff & ce_i;
	// only the low byte lane carries register data
	wire wr       = acc & we_i & sel_i[0];
	// reads have no side effect except on the status register
	wire rd       = acc & ~we_i;
	// address compares, word aligned offsets
	wire hit_ctl  = adr_i == {1'b0, NVC_OFS_CTRL};
	wire hit_loc  = adr_i == {1'b0, NVC_OFS_LOC};
	wire hit_val  = adr_i == {1'b0, NVC_OFS_VALUE};
	wire hit_stat = adr_i == {1'b0, NVC_OFS_STAT};
	wire hit_mask = adr_i == NVC_OFS_MASK_B;
	wire hit_flt  = adr_i == NVC_OFS_FAULT;
	wire busy     = st_ff == NVC_BUSY;
	// fault register bits model the aborting reset sources
	// aborting reset sources
	wire cut      = wr & hit_flt & (|dat_i[2:0]) & busy;
	// only a one starts, zero ignored
	wire start_st = wr & hit_ctl & dat_i[NVC_BIT_STORE] & en_ff & ~busy;
	wire start_fe = wr & hit_ctl & dat_i[NVC_BIT_FETCH] & ~busy & ~fetch_ff;
	wire done     = busy & ~cut & (cnt_ff == 16'(STORE_CYC - 1));
	wire [NVC_EV_W-1:0] ev;
	assign ev[NVC_EV_DONE]  = done;
	assign ev[NVC_EV_ABORT] = cut;
	assign ev[NVC_EV_FETCH] = fetch_ff;
	wire [7:0] ctl_rd = {4'h0, abort_ff, en_ff, busy, fetch_ff};
	wire [31:0] rdata = hit_ctl  ? {24'h0, ctl_rd} :
		hit_loc  ? {24'h0, 8'(loc_ff)} :
		hit_val  ? {24'h0, value_ff} :
		hit_stat ? {29'h0, stat_ff} :
		hit_mask ? {29'h0, mask_ff} : 32'h0;
	// read clears status; set wins over clear
	wire [NVC_EV_W-1:0] nxt_stat = (rd & hit_stat) ? ev : (stat_ff | ev);

	// bus answer: one wait state, ack the cycle after request
	// read data is held between reads so dat_o never glitches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0;
		end else if (ce_i) begin
			ack_ff <= acc;
			dat_ff <= rd ? rdata : dat_ff;
		end
	end

	// software registers
	// enable is rewritten by every control write, so software must keep it
	// set in the same word when it fetches or starts a store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loc_ff  <= '0;
			en_ff   <= 1'b0;
			mask_ff <= NVC_RST_EV;
		end else if (ce_i) begin
			if (wr & hit_loc)
				loc_ff <= dat_i[ADDR_W-1:0];
			if (wr & hit_ctl)
				en_ff <= dat_i[NVC_BIT_EN];
			if (wr & hit_mask)
				mask_ff <= dat_i[NVC_EV_W-1:0];
		end
	end

	// value register
	// a fetch wins over a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			value_ff <= NVC_RST_BYTE;
		end else if (ce_i) begin
			// byte lands with the fetch cycle
			if (fetch_ff)
				value_ff <= arr_rdata_i;
			else if (wr & hit_val & ~busy)
				value_ff <= dat_i[7:0];
		end
	end

	// fetch strobe and abort flag
	// abort is sticky until a store completes normally
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fetch_ff <= 1'b0;
			abort_ff <= 1'b0;
		end else if (ce_i) begin
			fetch_ff <= start_fe;
			// set on cut, cleared on normal finish
			if (cut)
				abort_ff <= 1'b1;
			else if (done)
				abort_ff <= 1'b0;
		end
	end

	// store engine
	// counts the store cycle; a cut ends it early with no array write
	// the array write pulse comes only from a finished cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff    <= NVC_IDLE;
			cnt_ff   <= 16'h0;
			arr_we_o <= 1'b0;
		end else if (ce_i) begin
			arr_we_o <= 1'b0;
			unique case (st_ff)
				NVC_IDLE: begin
					cnt_ff <= 16'h0;
					if (start_st)
						st_ff <= NVC_BUSY;
				end
				NVC_BUSY: begin
					cnt_ff <= cnt_ff + 16'h1;
					if (done) begin
						st_ff    <= NVC_IDLE;
						arr_we_o <= 1'b1;
					end else if (cut) begin
						st_ff <= NVC_IDLE;
					end
				end
				default: st_ff <= NVC_IDLE;
			endcase
		end
	end

	// events and interrupt
	// irq is computed from the next status so it rises with the flag
	// a status read that meets a new event keeps that event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_ff <= NVC_RST_EV;
			irq_ff  <= 1'b0;
		end else if (ce_i) begin
			stat_ff <= nxt_stat;
			irq_ff  <= |(nxt_stat & mask_ff);
		end
	end

	// array port
	// address mirrors the location register; the array answers unclocked
	// write data is a copy of the value register, taken in every enabled cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arr_addr_o  <= '0;
			arr_wdata_o <= 8'h0;
		end else if (ce_i) begin
			arr_addr_o  <= (wr & hit_loc) ? dat_i[ADDR_W-1:0] : arr_addr_o;
			arr_wdata_o <= value_ff;
		end
	end

	assign dat_o = dat_ff;
	assign ack_o = ack_ff;
	assign irq_o = irq_ff;

	// checks
	// every property is disabled in reset; those that look one cycle ahead
	// also require the clock enable, since a frozen cycle moves no state
	// covers below mark the fetch, store, abort and interrupt scenarios
	a_fetch_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && fetch_ff |=> !fetch_ff) else $error("fetch stuck high");
	a_fetch_data: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && fetch_ff |=> value_ff == $past(arr_rdata_i)) else $error("fetch data lost");
	a_no_en_store: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !en_ff && !busy |=> !busy) else $error("store without enable");
	a_zero_no_start: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_ctl && !dat_i[NVC_BIT_STORE] && !busy |=> !busy) else $error("zero started");
	a_cut_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		cut |=> abort_ff && !busy) else $error("abort not flagged");
	a_done_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && done |=> stat_ff[NVC_EV_DONE] && !busy) else $error("done not flagged");
	a_ok_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && done |=> !abort_ff) else $error("abort left set");
	a_value_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !fetch_ff && !(wr && hit_val) |=> $stable(value_ff)) else $error("value moved");
	a_ctl_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl_rd[7:4] == 4'h0) else $error("upper bits set");
	c_fetch: cover property (@(posedge clk_i) disable iff (rst_i) fetch_ff);
	c_store: cover property (@(posedge clk_i) disable iff (rst_i) done);
	c_abort: cover property (@(posedge clk_i) disable iff (rst_i) cut);
	// a store that ends with its interrupt unmasked
	c_done_irq: cover property (@(posedge clk_i) disable iff (rst_i)
		done && mask_ff[NVC_EV_DONE]);
	// status read that meets a new event
	c_read_race: cover property (@(posedge clk_i) disable iff (rst_i)
		rd && hit_stat && (|ev));
	// bus answer is a single cycle pulse
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && ack_ff |=> !ack_ff) else $error("ack held too long");
	// every taken request is answered next cycle
	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		acc |=> ack_ff) else $error("ack missing");
	// fetch start raises the strobe
	a_fetch_start: assert property (@(posedge clk_i) disable iff (rst_i)
		start_fe |=> fetch_ff) else $error("fetch not started");
	// zero in the fetch bit starts nothing
	a_fetch_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_ctl && !dat_i[NVC_BIT_FETCH] |=> !fetch_ff) else $error("zero fetched");
	// no fetch while storing
	a_fetch_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && busy |=> !fetch_ff) else $error("fetch during store");
	// store start makes the engine busy
	a_store_start: assert property (@(posedge clk_i) disable iff (rst_i)
		start_st |=> busy) else $error("store not started");
	// store bit clears at the end
	a_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && done |=> !ctl_rd[NVC_BIT_STORE]) else $error("store bit stuck");
	// finished store writes the array
	a_done_write: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && done |=> arr_we_o) else $error("array not written");
	// array write is one cycle
	a_write_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && arr_we_o |=> !arr_we_o) else $error("write pulse long");
	// store never outlasts its count
	a_store_len: assert property (@(posedge clk_i) disable iff (rst_i)
		busy |-> cnt_ff < 16'(STORE_CYC)) else $error("store overran");
	// abort flag sticks until a normal finish
	a_abort_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && abort_ff && !done |=> abort_ff) else $error("abort lost");
	// cut store raises the abort event
	a_abort_event: assert property (@(posedge clk_i) disable iff (rst_i)
		cut |=> stat_ff[NVC_EV_ABORT]) else $error("abort event lost");
	// value frozen while storing
	a_value_busy: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && busy && !fetch_ff |=> $stable(value_ff)) else $error("value moved busy");
	// enable only moves on a control write
	a_en_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !(wr && hit_ctl) |=> $stable(en_ff)) else $error("enable moved");
	// interrupt follows status and mask
	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !(wr && hit_mask) |=> irq_ff == |(stat_ff & mask_ff)) else $error("irq wrong");
	// mask only moves on a mask write
	a_mask_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !(wr && hit_mask) |=> $stable(mask_ff)) else $error("mask moved");
	// status read keeps only new events
	a_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && rd && hit_stat |=> stat_ff == $past(ev)) else $error("status not cleared");
	// array address follows location writes
	a_addr_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_loc |=> arr_addr_o == loc_ff) else $error("address stale");
	// write data mirrors the value register
	a_wdata_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i |=> arr_wdata_o == $past(value_ff)) else $error("write data stale");
endmodule

// *** dv/nvc_top_tb_top.sv ***
// testbench for the nv access block: wishbone tasks and directed tests
module nvc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import nvc_pkg::*;
	localparam int SC = 16; // short store cycle, still long enough to read busy twice
	localparam logic [4:0] CT = {1'b0, NVC_OFS_CTRL};
	localparam logic [4:0] LO = {1'b0, NVC_OFS_LOC};
	localparam logic [4:0] VA = {1'b0, NVC_OFS_VALUE};
	localparam logic [4:0] ST = {1'b0, NVC_OFS_STAT};
	localparam logic [31:0] FE = 32'h1 << NVC_BIT_FETCH;
	localparam logic [31:0] SO = 32'h1 << NVC_BIT_STORE;
	localparam logic [31:0] EN = 32'h1 << NVC_BIT_EN;
	localparam logic [31:0] AB = 32'h1 << NVC_BIT_ABORT;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i; // bench-driven controls
	logic [4:0]  adr_i;       // byte address
	logic [31:0] dat_i, dat_o; // bus data
	logic        ack_o, irq_o, arr_we_o; // design strobes
	logic [6:0]  arr_addr_o;  // array address
	logic [7:0]  arr_wdata_o, arr_rdata_i; // array data
	int          errors = 0;  // mismatches
	int          checks = 0;  // comparisons
	// array stand-in: byte derived from location, nonzero for the locations tested
	assign arr_rdata_i = {1'b0, arr_addr_o} ^ 8'h5a;
	nvc_top #(.ADDR_W(7), .STORE_CYC(SC)) u_nvc_top (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
		.arr_addr_o(arr_addr_o), .arr_we_o(arr_we_o), .arr_wdata_o(arr_wdata_o),
		.arr_rdata_i(arr_rdata_i));
	// clock, 100 ns period
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// classic cycle: hold request until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e, "read data");
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, run needs under two hundred cycles
	initial begin
		repeat (3000) @(posedge clk_i);
		errors++;
		summarize();
	end
	initial begin
		logic [6:0] loc;
		{rst_i, cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(CT, 32'h0);
		rd(5'h18, 32'h0);
		$display("test reset done");
		wr({1'b0, NVC_OFS_MASK_B}, 32'h0);
		// a low location and the top end of the location range
		for (int i = 0; i < 2; i++) begin
			loc = i ? 7'h7f : 7'h05;
			wr(LO, {25'h0, loc});
			wr(CT, FE);
			rd(VA, {24'h0, {1'b0, loc} ^ 8'h5a});
			rd(CT, 32'h0);
			rd(ST, 32'h1 << NVC_EV_FETCH);
			chk(irq_o, 1'b0, "masked irq");
		end
		wr(VA, 32'ha5);
		rd(CT, 32'h0);
		rd(VA, 32'ha5);
		$display("test fetch done");
		wr(CT, SO);
		rd(CT, 32'h0);
		wr(CT, EN);
		// each aborting reset kind cuts a running store
		for (int f = 0; f < 3; f++) begin
			wr(CT, EN | SO);
			wr({1'b0, NVC_OFS_FAULT}, 32'h1 << f);
			rd(CT, EN | AB);
			rd(ST, 32'h1 << NVC_EV_ABORT);
		end
		$display("test abort done");
		wr({1'b0, NVC_OFS_MASK_B}, 32'h1 << NVC_EV_DONE);
		wr(CT, EN | SO);
		rd(CT, EN | SO | AB);
		wr(CT, EN);
		rd(CT, EN | SO | AB);
		for (int n = 0; n < 20 && arr_we_o !== 1'b1; n++) @(posedge clk_i);
		chk(arr_we_o, 1'b1, "store pulse");
		chk(arr_wdata_o, 8'ha5, "store byte");
		chk({25'h0, arr_addr_o}, 32'h7f, "store address");
		repeat (2) @(posedge clk_i);
		rd(CT, EN);
		chk(irq_o, 1'b1, "done irq");
		rd(ST, 32'h1 << NVC_EV_DONE);
		@(posedge clk_i);
		chk(irq_o, 1'b0, "irq cleared");
		$display("test store done");
		summarize();
	end
endmodule
